/* File: verilog/vfs_pkg.sv */
// Function
// - core and generator exchange palette and pattern words
// - palette holds four bytes, or two low bytes
// - pixel index picks palette byte through mux
// - vga format drives selected byte unmodified
// - group steers byte; only masked pins drive
// - composite byte: luma, modulate bit, phase
// - modulate bit clear outputs luminance only
// - modulate bit set swings luma plus minus one, never below zero
// - broadcast carrier only while its clock runs
// - composite modulator makes baseband and broadcast outputs
// - four-color depth uses sixteen 2-bit indices
// - two-color depth uses thirty-two 1-bit indices
// - indices leave least significant bits first
// - four-color repeats top index until frame ends
// - two-color repeats top bit until frame ends
// - frame boundary loads words even without handoff
// - clocks per pixel zero means 256
// - clocks per frame zero means 4096
// - depth select 0 two-color, 1 four-color
// - format 00 off, 01 vga, 1x composite
package vfs_pkg;
    localparam int          CLK_MHZ           = 100;
    localparam int          BCAST_TIMEOUT_NS  = 1000;   // carrier declared dead after this
    localparam int          BCAST_TIMEOUT_CYC = (BCAST_TIMEOUT_NS * CLK_MHZ) / 1000;
    // register word indices, byte address is four times the index
    localparam logic [1:0]  REG_CONFIG        = 2'h0;
    localparam logic [1:0]  REG_SCALE         = 2'h1;
    localparam logic [1:0]  REG_STATUS        = 2'h2;
    localparam logic [31:0] CFG_RESET         = 32'h0000_0000;
    localparam logic [31:0] SCL_RESET         = 32'h0000_0000;
    localparam logic [31:0] CFG_WMASK         = 32'h7000_0eff;
    localparam logic [31:0] SCL_WMASK         = 32'h000f_ffff;
    localparam int          CFG_FMT_LSB       = 29;
    localparam int          CFG_DEPTH_BIT     = 28;
    localparam int          CFG_GROUP_LSB     = 9;
    localparam int          CFG_MASK_LSB      = 0;
    localparam int          SCL_CPP_LSB       = 12;
    localparam int          SCL_CPF_LSB       = 0;
    localparam int          STS_IDX_LSB       = 8;
    localparam int          STS_LOADED_BIT    = 16;
    localparam int          STS_BCAST_BIT     = 17;
    localparam logic [1:0]  FMT_OFF           = 2'h0;
    localparam logic [1:0]  FMT_VGA           = 2'h1;
    localparam logic [1:0]  FMT_COMP1         = 2'h2;
    localparam logic [1:0]  FMT_COMP2         = 2'h3;
    localparam logic [8:0]  CPP_ZERO          = 9'h100;
    localparam logic [12:0] CPF_ZERO          = 13'h1000;
    localparam logic [4:0]  PIX4_LAST         = 5'h0f;
    localparam logic [4:0]  PIX2_LAST         = 5'h1f;
    localparam logic [2:0]  GROUP_MAX         = 3'h3;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } vfs_state_type;
endpackage

/* File: verilog/vfs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser; first stage feeds only the second
module vfs_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             ref_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    // both stages reset to a constant
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/vfs_modulator.sv */
`timescale 1ns/1ps
`default_nettype none
// composite modulator: byte plus carrier phase to a 4-bit baseband level
module vfs_modulator (
    input  wire logic [7:0] color_i,
    input  wire logic [3:0] phase_i,
    output logic      [3:0] level_o
);
    logic [2:0] luma;
    logic       mod_en;
    logic [3:0] hue;
    logic [3:0] angle;
    logic [3:0] up;
    logic [3:0] down;

    // field split of the color byte
    assign luma   = color_i[2:0];
    assign mod_en = color_i[3];
    assign hue    = color_i[7:4];
    assign angle  = phase_i + hue;
    assign up     = {1'b0, luma} + 4'h1;
    // clamp at black rather than wrap to full white
    assign down   = (luma == 3'h0) ? 4'h0 : ({1'b0, luma} - 4'h1);
    assign level_o = !mod_en ? {1'b0, luma}
                   : (angle[3] ? down : up);
endmodule
`default_nettype wire

/* File: verilog/vfs_serializer.sv */
`timescale 1ns/1ps
`default_nettype none
module vfs_serializer (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [1:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        frame_handoff_wait_i,
    input  wire logic [31:0] palette_i,
    input  wire logic [31:0] pattern_i,
    output logic             handoff_done_o,
    input  wire logic        pixel_pll_clock_i,
    input  wire logic        broadcast_pll_clock_i,
    output logic      [31:0] pins_o,
    output logic      [31:0] pins_oe_o
);
    logic [1:0]  clk_s;
    logic        pix_d;
    logic        bc_d;
    logic [31:0] cfg_q;
    logic [31:0] scl_q;
    logic [31:0] palette_q;
    logic [31:0] pattern_q;
    logic [12:0] frame_cnt;
    logic [8:0]  pix_cnt;
    logic [4:0]  idx;
    logic [3:0]  phase;
    logic [7:0]  frame_num;
    logic        loaded;
    logic [15:0] bc_timer;
    vfs_pkg::vfs_state_type state;

    // both pll clocks arrive from outside and are resampled here
    vfs_sync #(
        .WIDTH (2)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({broadcast_pll_clock_i, pixel_pll_clock_i}),
        .sync_o    (clk_s)
    );

    // edge finders on the synchronised levels
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pix_d <= 1'b0;
            bc_d  <= 1'b0;
        end else begin
            pix_d <= clk_s[0];
            bc_d  <= clk_s[1];
        end
    end

    wire pix_tick = clk_s[0] & ~pix_d;
    wire bc_edge  = clk_s[1] & ~bc_d;

    // bus decode
    wire        bus_req  = avs_read_i | avs_write_i;
    wire        bus_fire = bus_req & ~avs_waitrequest_o;
    wire        wr_fire  = avs_write_i & bus_fire;
    wire        sel_cfg  = avs_address_i == vfs_pkg::REG_CONFIG;
    wire        sel_scl  = avs_address_i == vfs_pkg::REG_SCALE;
    wire        sel_sts  = avs_address_i == vfs_pkg::REG_STATUS;
    wire [31:0] be_mask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                            {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    wire [31:0] cfg_wm   = be_mask & vfs_pkg::CFG_WMASK;
    wire [31:0] scl_wm   = be_mask & vfs_pkg::SCL_WMASK;
    wire [31:0] next_cfg = (cfg_q & ~cfg_wm) | (avs_writedata_i & cfg_wm);
    wire [31:0] next_scl = (scl_q & ~scl_wm) | (avs_writedata_i & scl_wm);

    // configuration fields
    wire [1:0]  fmt   = cfg_q[vfs_pkg::CFG_FMT_LSB +: 2];
    wire        depth = cfg_q[vfs_pkg::CFG_DEPTH_BIT];
    wire [2:0]  group = cfg_q[vfs_pkg::CFG_GROUP_LSB +: 3];
    wire [7:0]  mask  = cfg_q[vfs_pkg::CFG_MASK_LSB +: 8];
    wire [7:0]  cpp   = scl_q[vfs_pkg::SCL_CPP_LSB +: 8];
    wire [11:0] cpf   = scl_q[vfs_pkg::SCL_CPF_LSB +: 12];
    wire [8:0]  cpp_eff = (cpp == 8'h00) ? vfs_pkg::CPP_ZERO : {1'b0, cpp};
    wire [12:0] cpf_eff = (cpf == 12'h000) ? vfs_pkg::CPF_ZERO : {1'b0, cpf};
    wire        enabled = fmt != vfs_pkg::FMT_OFF;
    wire        bc_on   = bc_timer != 16'h0000;

    wire [31:0] status  = {14'h0000, bc_on, loaded, 3'h0, idx, frame_num};
    wire [31:0] rd_mux  = sel_cfg ? cfg_q : sel_scl ? scl_q : sel_sts ? status : 32'h0;

    // one wait cycle per access; unmapped reads give zero, writes drop
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else begin
            avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
            if (bus_req & avs_waitrequest_o) begin
                avs_readdata_o <= rd_mux;
            end
        end
    end

    // writable registers take effect on the accepting edge only
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cfg_q <= vfs_pkg::CFG_RESET;
            scl_q <= vfs_pkg::SCL_RESET;
        end else if (wr_fire) begin
            if (sel_cfg) begin
                cfg_q <= next_cfg;
            end
            if (sel_scl) begin
                scl_q <= next_scl;
            end
        end
    end

    // frame sequencing
    wire        frame_load = (state == vfs_pkg::ST_RUN) & pix_tick & (frame_cnt == 13'h0001);
    wire        pix_end    = pix_tick & (pix_cnt == 9'h001);
    wire [4:0]  idx_last   = depth ? vfs_pkg::PIX4_LAST : vfs_pkg::PIX2_LAST;
    wire        idx_hold   = idx == idx_last;
    wire [4:0]  next_idx   = idx_hold ? idx : idx + 5'h01;
    wire [4:0]  pos2       = {idx[3:0], 1'b0};

    // run/idle control; leaving the run state drops the picture
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state <= vfs_pkg::ST_IDLE;
        end else begin
            unique case (state)
                vfs_pkg::ST_IDLE: begin
                    if (enabled) begin
                        state <= vfs_pkg::ST_RUN;
                    end
                end
                vfs_pkg::ST_RUN: begin
                    if (!enabled) begin
                        state <= vfs_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // word latch: the boundary fetches whatever the core presents
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            palette_q      <= 32'h0000_0000;
            pattern_q      <= 32'h0000_0000;
            handoff_done_o <= 1'b0;
        end else begin
            handoff_done_o <= frame_load & frame_handoff_wait_i;
            if (frame_load) begin
                palette_q <= palette_i;
                pattern_q <= pattern_i;
            end
        end
    end

    // pixel and frame counters run on pixel clock edges only
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || state == vfs_pkg::ST_IDLE) begin
            frame_cnt <= 13'h0001;
            pix_cnt   <= 9'h001;
            idx       <= 5'h00;
        end else if (frame_load) begin
            frame_cnt <= cpf_eff;
            pix_cnt   <= cpp_eff;
            idx       <= 5'h00;
        end else if (pix_tick) begin
            frame_cnt <= frame_cnt - 13'h0001;
            pix_cnt   <= pix_end ? cpp_eff : pix_cnt - 9'h001;
            if (pix_end) begin
                idx <= next_idx;
            end
        end
    end

    // picture valid flag and frame tally for status
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            loaded    <= 1'b0;
            frame_num <= 8'h00;
        end else begin
            loaded    <= (state == vfs_pkg::ST_RUN) & enabled & (loaded | frame_load);
            frame_num <= frame_num + {7'h00, frame_load};
        end
    end

    // chroma phase steps once per pixel clock, sixteen steps a cycle
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            phase <= 4'h0;
        end else if (pix_tick) begin
            phase <= phase + 4'h1;
        end
    end

    // broadcast clock watchdog; a stopped pll silences the carrier
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            bc_timer <= 16'h0000;
        end else if (bc_edge) begin
            bc_timer <= 16'(vfs_pkg::BCAST_TIMEOUT_CYC);
        end else if (bc_on) begin
            bc_timer <= bc_timer - 16'h0001;
        end
    end

    // palette byte selection
    wire [1:0]  sel_four   = pattern_q[pos2 +: 2];
    wire        sel_two    = pattern_q[idx];
    wire [1:0]  color_sel  = depth ? sel_four : {1'b0, sel_two};
    wire [7:0]  color_byte = palette_q[{color_sel, 3'b000} +: 8];
    wire [3:0]  base_lvl;

    vfs_modulator u_mod (
        .color_i (color_byte),
        .phase_i (phase),
        .level_o (base_lvl)
    );

    // carrier-keyed copy of the baseband level forms the broadcast half
    wire        bc_lvl  = bc_on & clk_s[1];
    wire [3:0]  air_lvl = bc_lvl ? base_lvl : 4'h0;
    wire [7:0]  out8    = (fmt == vfs_pkg::FMT_VGA)   ? color_byte
                        : (fmt == vfs_pkg::FMT_COMP1) ? {air_lvl, base_lvl}
                        : {base_lvl, air_lvl};
    wire        group_ok = group <= vfs_pkg::GROUP_MAX;
    wire [4:0]  shift    = {group[1:0], 3'b000};
    wire        drive    = loaded & enabled & group_ok;
    wire [31:0] mask_w   = {24'h000000, mask} << shift;
    wire [31:0] next_pins = drive ? ({24'h000000, out8} << shift) : 32'h0000_0000;
    wire [31:0] next_oe   = drive ? mask_w : 32'h0000_0000;

    // pins are registered; reserved groups drive nothing
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pins_o    <= 32'h0000_0000;
            pins_oe_o <= 32'h0000_0000;
        end else begin
            pins_o    <= next_pins & next_oe;
            pins_oe_o <= next_oe;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_handoff_release: assert property (frame_load |=> handoff_done_o == $past(frame_handoff_wait_i))
        else $error("core not released at frame latch");
    a_words_latched: assert property (frame_load |=> palette_q == $past(palette_i) && pattern_q == $past(pattern_i))
        else $error("frame words not latched at boundary");
    a_pixel_reload: assert property (frame_load |=> pix_cnt == $past(cpp_eff) && idx == 5'h00)
        else $error("pixel count not reloaded");
    a_frame_reload: assert property (frame_load && cpf == 12'h000 |=> frame_cnt == 13'h1000)
        else $error("zero frame count not 4096");
    a_index_hold: assert property (pix_end && !frame_load && idx_hold |=> idx == $past(idx))
        else $error("top index not repeated");
    a_two_color: assert property (!depth |-> color_sel[1] == 1'b0)
        else $error("two-color reached upper palette");
    a_vga_raw: assert property (drive && fmt == vfs_pkg::FMT_VGA && group == 3'h0 && mask == 8'hff |=> pins_o[7:0] == $past(color_byte))
        else $error("vga byte altered");
    a_mask_gate: assert property ((pins_oe_o & ~$past(mask_w)) == 32'h0000_0000)
        else $error("unmasked pin driven");
    a_luma_only: assert property (!color_byte[3] |-> base_lvl == {1'b0, color_byte[2:0]})
        else $error("luma modified without modulate bit");
    a_mod_swing: assert property (color_byte[3] && color_byte[2:0] != 3'h0 |-> base_lvl == {1'b0, color_byte[2:0]} + 4'h1 || base_lvl == {1'b0, color_byte[2:0]} - 4'h1)
        else $error("modulated luma not plus or minus one");
    a_off_quiet: assert property (fmt == vfs_pkg::FMT_OFF |=> ##1 pins_oe_o == 32'h0000_0000)
        else $error("pins driven while disabled");
    a_no_carrier: assert property (drive && fmt == vfs_pkg::FMT_COMP1 && group == 3'h0 && !bc_on |=> pins_o[7:4] == 4'h0)
        else $error("carrier check");

    c_frame_load:   cover property (frame_load ##[1:1000] frame_load);
    c_top_repeat:   cover property (pix_end && idx_hold && !frame_load);
    c_modulated:    cover property (drive && fmt[1] && color_byte[3]);
    c_carrier_live: cover property (drive && fmt[1] && bc_lvl);
endmodule
`default_nettype wire

/* File: verif/vfs_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// processor core side of the handoff: stalls with both words, leaves for one cycle when released
module vfs_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        stall_i,
    input  wire logic        done_i,
    input  wire logic [31:0] palette_i,
    input  wire logic [31:0] pattern_i,
    output logic             wait_o,
    output logic      [31:0] palette_o,
    output logic      [31:0] pattern_o
);
    logic gap;

    // one cycle away after each release, as a core fetching its next words would be
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap <= 1'b0;
        end else begin
            gap <= done_i;
        end
    end

    // waits before the boundary whenever told to stall
    assign wait_o    = stall_i & ~gap & ~rst_i;
    // both words valid together only while waiting; otherwise the buses carry other data
    assign palette_o = wait_o ? palette_i : ~palette_i;
    assign pattern_o = wait_o ? pattern_i : ~pattern_i;
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic        pix   = 1'b0;
    logic        bcast = 1'b0;
    logic [1:0]  addr  = 2'h0;
    logic        rd    = 1'b0;
    logic        wr    = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be    = 4'hf;
    logic        stall = 1'b0;
    logic [31:0] pal   = 32'h0;
    logic [31:0] pat   = 32'h0;
    logic [31:0] rdata, pins, oe, cpal, cpat, q;
    logic [31:0] smp [0:39];
    logic [31:0] soe [0:39];
    logic [7:0]  c0;
    logic        wait_req, core_wait, done;
    int          failures = 0;
    int          n_checks = 0;
    int          cycles   = 0;
    int          nd;

    vfs_serializer i_vfs_serializer (.ref_clk_i(clk), .sys_rst_i(rst), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .frame_handoff_wait_i(core_wait),
        .palette_i(cpal), .pattern_i(cpat), .handoff_done_o(done), .pixel_pll_clock_i(pix),
        .broadcast_pll_clock_i(bcast), .pins_o(pins), .pins_oe_o(oe));
    vfs_core_model i_vfs_core_model (.clk_i(clk), .rst_i(rst), .stall_i(stall), .done_i(done),
        .palette_i(pal), .pattern_i(pat), .wait_o(core_wait), .palette_o(cpal),
        .pattern_o(cpat));

    // free-running clocks with unrelated phases
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #3;
        forever #40 pix = ~pix;
    end
    initial begin
        forever #17 bcast = ~bcast;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one Avalon access; outputs read right after the edge hold their sampled value
    task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        addr  <= a;
        wr    <= w;
        rd    <= !w;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        r = rdata;
        if (n >= 50) failures++;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wreg(input logic [1:0] a, input logic [31:0] d);
        logic [31:0] s;
        bus(1'b1, a, d, s);
    endtask

    task automatic rchk(input string what, input logic [1:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, q);
        chk(what, exp, q);
    endtask

    // palette byte expected for pixel k; index repeats its top bits past the word
    function automatic logic [7:0] pick(input logic [31:0] p, input logic [31:0] t,
                                        input logic four, input int k);
        logic [1:0] idx;
        if (four) idx = (k < 16) ? t[2*k +: 2] : t[31:30];
        else idx = {1'b0, (k < 32) ? t[k] : t[31]};
        return p[8*idx +: 8];
    endfunction

    // enable, wait for the handoff, then sample mid-pixel n times, then disable
    task automatic run_frame(input logic [31:0] cfg, input logic [31:0] scl,
                             input logic [31:0] p, input logic [31:0] t, input int per,
                             input int n);
        int k;
        pal   <= p;
        pat   <= t;
        stall <= 1'b1;
        wreg(vfs_pkg::REG_SCALE, scl);
        wreg(vfs_pkg::REG_CONFIG, cfg);
        k = 0;
        while (done !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        chk("handoff release", 32'h1, {31'h0, done});
        repeat (per / 2) @(posedge clk);
        for (k = 0; k < n; k++) begin
            smp[k] = pins;
            soe[k] = oe;
            repeat (per) @(posedge clk);
        end
        wreg(vfs_pkg::REG_CONFIG, 32'h0);
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard; the whole run needs well under a quarter of this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // registers: reset values, masked writes, lanes, unmapped index
        rchk("config reset", vfs_pkg::REG_CONFIG, vfs_pkg::CFG_RESET);
        rchk("scale reset", vfs_pkg::REG_SCALE, vfs_pkg::SCL_RESET);
        be <= 4'h0;
        wreg(vfs_pkg::REG_SCALE, 32'hffff_ffff);
        be <= 4'hf;
        rchk("scale no lanes", vfs_pkg::REG_SCALE, vfs_pkg::SCL_RESET);
        wreg(vfs_pkg::REG_CONFIG, 32'hffff_ffff);
        rchk("config mask", vfs_pkg::REG_CONFIG, vfs_pkg::CFG_WMASK);
        wreg(vfs_pkg::REG_CONFIG, 32'h0);
        wreg(2'h3, 32'hffff_ffff);
        rchk("unmapped", 2'h3, 32'h0);
        $display("test registers done");

        // vga, four colors, group 1, frame longer than 16 pixels
        run_frame({1'b0, vfs_pkg::FMT_VGA, 1'b1, 16'h0, 3'h1, 1'b0, 8'hff},
                  {12'h0, 8'h02, 12'd40}, 32'hd4c3_b2a1, 32'hb1e4_1b72, 16, 20);
        for (int k = 0; k < 20; k++) begin
            chk("vga4 pins", {16'h0, pick(32'hd4c3_b2a1, 32'hb1e4_1b72, 1'b1, k), 8'h0}, smp[k]);
            chk("vga4 oe", 32'h0000_ff00, soe[k]);
        end
        $display("test vga four color done");

        // vga, two colors, group 3, low nibble masked in, frame longer than 32 pixels
        run_frame({1'b0, vfs_pkg::FMT_VGA, 1'b0, 16'h0, 3'h3, 1'b0, 8'h0f},
                  {12'h0, 8'h01, 12'd40}, 32'h0000_5a3c, 32'h8000_f00d, 8, 40);
        for (int k = 0; k < 40; k++) begin
            chk("vga2 pins", {pick(32'h0000_5a3c, 32'h8000_f00d, 1'b0, k) & 8'h0f, 24'h0}, smp[k]);
            chk("vga2 oe", 32'h0f00_0000, soe[k]);
        end
        $display("test vga two color done");

        // composite: modulated byte swings luma by one, plain byte gives luma only
        run_frame({1'b0, vfs_pkg::FMT_COMP1, 1'b0, 16'h0, 3'h0, 1'b0, 8'h0f},
                  {12'h0, 8'h01, 12'd40}, 32'h0000_1d05, 32'h0000_ffff, 8, 40);
        for (int k = 0; k < 40; k++) begin
            if (k < 16) chk("modulated", 32'h1, {31'h0, smp[k] === 32'h4 || smp[k] === 32'h6});
            else chk("luma only", 32'h5, smp[k]);
            chk("comp oe", 32'h0000_000f, soe[k]);
        end
        bus(1'b0, vfs_pkg::REG_STATUS, 32'h0, q);
        chk("carrier alive", 32'h1, {31'h0, q[vfs_pkg::STS_BCAST_BIT]});
        $display("test composite done");

        // core never waits: frames still load, no release pulse
        stall <= 1'b0;
        // zero counts stand for 256 and 4096; only the first load falls inside the wait
        wreg(vfs_pkg::REG_SCALE, 32'h0000_0000);
        bus(1'b0, vfs_pkg::REG_STATUS, 32'h0, q);
        c0 = q[7:0];
        wreg(vfs_pkg::REG_CONFIG, {1'b0, vfs_pkg::FMT_VGA, 1'b1, 16'h0, 3'h0, 1'b0, 8'hff});
        nd = 0;
        repeat (700) begin
            @(posedge clk);
            if (done === 1'b1) nd++;
        end
        bus(1'b0, vfs_pkg::REG_STATUS, 32'h0, q);
        chk("no release", 32'h0, nd);
        chk("frames loaded", 32'h1, {31'h0, q[7:0] !== c0});
        wreg(vfs_pkg::REG_CONFIG, 32'h0);
        repeat (4) @(posedge clk);
        chk("off oe", 32'h0, oe);
        $display("test unattended load done");
        finish_test();
    end
endmodule
`default_nettype wire
